// ==== src/rss_regs.svh ====
`ifndef RSS_REGS_SVH
`define RSS_REGS_SVH
// Operation
// - After power-on the internal power-on reset stays asserted for 300 ms of the 32 kHz slow reference clock.
// - The SDRAM reset is stretched to 7K slow reference clock cycles by its own stretcher.
// - The internal system reset is stretched to 14K slow cycles and the same reset drives the reset output pin.
// - A hard-reset request passes a qualifier counting 4K slow cycles before it counts as valid.

// ----------------------------------------
// Timing figures, in their own units
// ----------------------------------------
`define RSS_POR_MS 300
`define RSS_SLOW_KHZ 32
`define RSS_KCYC 1024
`define RSS_SDRAM_K 7
`define RSS_SYS_K 14
`define RSS_QUAL_K 4
`define RSS_REQ_MIN 4

// ----------------------------------------
// Derived counts, in slow clock cycles, and the counter width
// ----------------------------------------
`define RSS_POR_CYC (`RSS_POR_MS * `RSS_SLOW_KHZ)
`define RSS_SDRAM_CYC (`RSS_SDRAM_K * `RSS_KCYC)
`define RSS_SYS_CYC (`RSS_SYS_K * `RSS_KCYC)
`define RSS_QUAL_CYC (`RSS_QUAL_K * `RSS_KCYC)
`define RSS_CNT_W 16
`endif

// ==== src/rss_pkg.sv ====
package rss_pkg;
   // Hard-reset qualifier progress
   typedef enum logic [1:0] {
      RSS_Q_IDLE,
      RSS_Q_ARM,
      RSS_Q_WAIT,
      RSS_Q_VALID
   } rss_qual_t;
   typedef logic [15:0] rss_cnt_t;
endpackage

// ==== src/rss_reset_stretch_sequencer.sv ====
`timescale 1ns/1ps
`include "rss_regs.svh"
module rss_reset_stretch_sequencer #(
   parameter rss_pkg::rss_cnt_t POR_CYC = rss_pkg::rss_cnt_t'(`RSS_POR_CYC),
   parameter rss_pkg::rss_cnt_t SDRAM_CYC = rss_pkg::rss_cnt_t'(`RSS_SDRAM_CYC),
   parameter rss_pkg::rss_cnt_t SYS_CYC = rss_pkg::rss_cnt_t'(`RSS_SYS_CYC),
   parameter rss_pkg::rss_cnt_t QUAL_CYC = rss_pkg::rss_cnt_t'(`RSS_QUAL_CYC)
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // Board slow clock and reset sources
   input wire logic slow_ref_clk_in,
   input wire logic power_on_rst_n_in,
   input wire logic hard_rst_n_in,
   // Reset outputs
   output logic int_por_out,
   output logic sdram_rst_n_out,
   output logic internal_system_reset_n_out,
   output logic rst_pin_n_out
);
   import rss_pkg::*;

   // ----------------------------------------
   // Shared stretch step
   // ----------------------------------------
   // Reload while the source is active, count one slow tick at a time after
   function automatic rss_cnt_t stretch_nxt(input rss_cnt_t cnt, input logic src,
                                           input logic tick, input rss_cnt_t len);
      rss_cnt_t r;
      r = cnt;
      if (src) begin
         r = len;
      end else if (tick && cnt != '0) begin
         r = cnt - rss_cnt_t'(1);
      end
      return r;
   endfunction

   // Last tick of a count: true on the tick that takes it from one to zero.
   // Shared by every stretcher, so all releases follow the same end point.
   function automatic logic stretch_done(input rss_cnt_t cnt, input logic tick);
      logic d;
      d = tick && (cnt <= rss_cnt_t'(1));
      return d;
   endfunction

   // ----------------------------------------
   // Slow reference clock tick
   // ----------------------------------------
   logic slow_q_r;
   logic tick;

   // Sampled as data, not used as a clock, so one domain is kept.
   // Reset value is high: a slow clock already high when reset lifts must
   // not read as a fresh edge; the cost is at most one late tick.
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         slow_q_r <= 1'b1;
      end else begin
         slow_q_r <= slow_ref_clk_in;
      end
   end
   // One-cycle tick on each rising edge of the slow reference clock
   assign tick = slow_ref_clk_in & ~slow_q_r;

   // ----------------------------------------
   // Internal power-on reset
   // ----------------------------------------
   rss_cnt_t por_cnt_r;
   logic por_act_r;

   // Held while the input is low, then for the full count after release.
   // A board that already holds the input high still gets a full count,
   // timed from the release of the clock-domain reset.
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         por_cnt_r <= POR_CYC;
         por_act_r <= 1'b1;
      end else begin
         por_cnt_r <= stretch_nxt(por_cnt_r, ~power_on_rst_n_in, tick, POR_CYC);
         if (!power_on_rst_n_in) begin
            por_act_r <= 1'b1;
         end else if (stretch_done(por_cnt_r, tick)) begin
            por_act_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Hard-reset qualifier
   // ----------------------------------------
   rss_qual_t q_state_r;
   rss_cnt_t q_cnt_r;

   // Last count of the minimum-width check; fixed by the header, not a parameter,
   // because the board-side minimum is not something a user may trade away
   localparam rss_cnt_t REQ_LAST = rss_cnt_t'(`RSS_REQ_MIN - 1);

   // Needs the minimum width of low samples, then the qualify count;
   // a short glitch is thrown away rather than resetting the chip
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         q_state_r <= RSS_Q_IDLE;
         q_cnt_r <= '0;
      end else begin
         case (q_state_r)
            RSS_Q_IDLE: begin
               // A tick in the cycle the request is first seen counts too,
               // else a request of exactly the minimum width could be lost
               if (!hard_rst_n_in) begin
                  q_state_r <= RSS_Q_ARM;
                  q_cnt_r <= rss_cnt_t'(tick);
               end else begin
                  q_cnt_r <= '0;
               end
            end
            RSS_Q_ARM: begin
               // Input rising before the minimum width drops the request silently
               if (hard_rst_n_in) begin
                  q_state_r <= RSS_Q_IDLE;
               end else if (tick) begin
                  if (q_cnt_r == REQ_LAST) begin
                     q_state_r <= RSS_Q_WAIT;
                     q_cnt_r <= QUAL_CYC;
                  end else begin
                     q_cnt_r <= q_cnt_r + rss_cnt_t'(1);
                  end
               end
            end
            RSS_Q_WAIT: begin
               // Input no longer watched: a request that passed the width check
               // always ends in one full stretch, even if it is withdrawn now
               if (tick) begin
                  if (q_cnt_r <= rss_cnt_t'(1)) begin
                     q_state_r <= RSS_Q_VALID;
                  end
                  q_cnt_r <= q_cnt_r - rss_cnt_t'(1);
               end
            end
            RSS_Q_VALID: begin
               // Stays a live source until the request is withdrawn
               if (hard_rst_n_in) begin
                  q_state_r <= RSS_Q_IDLE;
               end
            end
            default: begin
               q_state_r <= RSS_Q_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Combined reset source
   // ----------------------------------------
   logic hard_ok;
   logic src;

   // A hard request only counts once it has passed the qualifier
   assign hard_ok = (q_state_r == RSS_Q_VALID);
   // Any live source holds the SDRAM and system stretchers at their full length;
   // a new source during a stretch restarts it from the top
   assign src = por_act_r | hard_ok;

   // ----------------------------------------
   // SDRAM reset stretcher
   // ----------------------------------------
   rss_cnt_t sd_cnt_r;
   logic sd_act_r;

   // Own counter, so the memory side can be let go before the core
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         sd_cnt_r <= SDRAM_CYC;
      end else begin
         sd_cnt_r <= stretch_nxt(sd_cnt_r, src, tick, SDRAM_CYC);
      end
   end

   // Asserts in the cycle after a source appears; falls on the last tick
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         sd_act_r <= 1'b1;
      end else if (src) begin
         sd_act_r <= 1'b1;
      end else if (stretch_done(sd_cnt_r, tick)) begin
         sd_act_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // System reset stretcher
   // ----------------------------------------
   rss_cnt_t sys_cnt_r;
   logic sys_act_r;

   // Longer count, so memory is out of reset before the core starts
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         sys_cnt_r <= SYS_CYC;
      end else begin
         sys_cnt_r <= stretch_nxt(sys_cnt_r, src, tick, SYS_CYC);
      end
   end

   // Same assert and release pattern as the SDRAM side
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         sys_act_r <= 1'b1;
      end else if (src) begin
         sys_act_r <= 1'b1;
      end else if (stretch_done(sys_cnt_r, tick)) begin
         sys_act_r <= 1'b0;
      end
   end

   // Registered outputs; pin mirrors system reset
   // At most an inverter sits between each flop and its pin, so no glitches leave
   assign int_por_out = por_act_r;
   assign sdram_rst_n_out = ~sd_act_r;
   assign internal_system_reset_n_out = ~sys_act_r;
   assign rst_pin_n_out = ~sys_act_r;
endmodule

// ==== tb/rss_chk_assertions.sv ====
`timescale 1ns/1ps
module rss_chk_assertions (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic power_on_rst_n_in,
   input wire logic int_por_out,
   input wire logic sdram_rst_n_out,
   input wire logic internal_system_reset_n_out,
   input wire logic rst_pin_n_out
);
   // One domain, so clock and disable are shared
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   // Power-on source, then its two-step fan-out
   sequence s_por_req;
      !power_on_rst_n_in;
   endsequence
   sequence s_fan_out;
      int_por_out ##1 !sdram_rst_n_out;
   endsequence
   a_por_fan_out: assert property (s_por_req |=> s_fan_out) else $error("por fan-out late");
   a_por_holds_all: assert property (int_por_out |=> !internal_system_reset_n_out) else $error("sys free");
   a_pin_mirrors: assert property (rst_pin_n_out == internal_system_reset_n_out) else $error("pin differs");
   a_sdram_first: assert property ($rose(internal_system_reset_n_out) |-> sdram_rst_n_out) else $error("order");
   a_sdram_clean: assert property ($rose(sdram_rst_n_out) |-> !int_por_out) else $error("sdram early");
   a_por_needs_in: assert property ($fell(int_por_out) |-> power_on_rst_n_in) else $error("por early");
endmodule

// ==== tb/rss_board_model.sv ====
`timescale 1ns/1ps
module rss_board_model (
   input wire logic mclk_in,
   output logic slow_ref_clk_out,
   output logic power_on_rst_n_out,
   output logic hard_rst_n_out
);
   logic [1:0] div_r = 2'h0;
   // Slow clock at mclk/4, far faster than real, to keep runs short
   always @(posedge mclk_in) div_r <= div_r + 2'h1;
   assign slow_ref_clk_out = div_r[1];
   // Board starts in power-on reset
   initial begin
      power_on_rst_n_out = 1'b0;
      hard_rst_n_out = 1'b1;
   end
   // Hard request held for n slow edges; call just after an mclk edge
   task hold_hard(input int n);
      hard_rst_n_out <= 1'b0;
      repeat (n) @(posedge slow_ref_clk_out);
      @(posedge mclk_in);
      hard_rst_n_out <= 1'b1;
   endtask
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
   logic mclk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic slow_ref_clk_in, power_on_rst_n_in, hard_rst_n_in;
   logic int_por_out, sdram_rst_n_out, internal_system_reset_n_out, rst_pin_n_out;
   int n_fail = 0;
   int total_checks = 0;
   int n;
   // Hold ticks, expected sys level, window of cycles to assert
   int rows [3][4] = '{'{2, 1, 400, 400}, '{4, 0, 10, 22}, '{6, 0, 3, 14}};
   always #25 mclk_in = ~mclk_in;
   rss_board_model b (.mclk_in(mclk_in), .slow_ref_clk_out(slow_ref_clk_in),
      .power_on_rst_n_out(power_on_rst_n_in), .hard_rst_n_out(hard_rst_n_in));
   rss_reset_stretch_sequencer #(.POR_CYC(16'h000a), .SDRAM_CYC(16'h0007), .SYS_CYC(16'h000e),
      .QUAL_CYC(16'h0004)) uut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .slow_ref_clk_in(slow_ref_clk_in),
      .power_on_rst_n_in(power_on_rst_n_in), .hard_rst_n_in(hard_rst_n_in), .int_por_out(int_por_out),
      .sdram_rst_n_out(sdram_rst_n_out), .internal_system_reset_n_out(internal_system_reset_n_out),
      .rst_pin_n_out(rst_pin_n_out));
   task chk(input logic seen, input logic exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t mismatch", $time);
      end
   endtask
   // Cycles until an output reaches lvl; capped so a stuck one ends
   task wt(input int sel, input logic lvl, output int c);
      logic v;
      c = 0;
      do begin
         @(posedge mclk_in);
         #1;
         v = sel == 0 ? int_por_out : sel == 1 ? sdram_rst_n_out : internal_system_reset_n_out;
         c++;
      end while (v !== lvl && c < 400);
   endtask
   task close_out;
      $display("checks %0d fails %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (3) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      #1;
      chk(int_por_out, 1'b1);
      chk(sdram_rst_n_out, 1'b0);
      @(posedge mclk_in);
      b.power_on_rst_n_out <= 1'b1;
      wt(0, 1'b0, n);
      chk(n >= 36 && n <= 45, 1'b1);
      wt(1, 1'b1, n);
      chk(n >= 24 && n <= 32, 1'b1);
      wt(2, 1'b1, n);
      chk(n >= 24 && n <= 60, 1'b1);
      chk(rst_pin_n_out, 1'b1);
      $display("power-on test done");
      foreach (rows[i]) begin
         @(posedge mclk_in);
         b.hold_hard(rows[i][0]);
         wt(2, 1'b0, n);
         chk(internal_system_reset_n_out, rows[i][1][0]);
         chk(n >= rows[i][2] && n <= rows[i][3], 1'b1);
         wt(2, 1'b1, n);
         chk(sdram_rst_n_out, 1'b1);
         $display("hard test %0d done", i);
      end
      // Reset in mid-run: all outputs to reset level, then a full power-on count
      @(posedge mclk_in);
      rst_n_in <= 1'b0;
      repeat (2) @(posedge mclk_in);
      #1;
      chk(int_por_out, 1'b1);
      chk(sdram_rst_n_out, 1'b0);
      chk(internal_system_reset_n_out, 1'b0);
      chk(rst_pin_n_out, 1'b0);
      @(posedge mclk_in);
      rst_n_in <= 1'b1;
      wt(0, 1'b0, n);
      chk(n >= 36 && n <= 45, 1'b1);
      wt(2, 1'b1, n);
      chk(n >= 54 && n <= 58, 1'b1);
      $display("mid-run reset test done");
      // Short power-on pulse: power-on reset asserts at once, SDRAM reset a cycle later, then a fresh full count
      @(posedge mclk_in);
      b.power_on_rst_n_out <= 1'b0;
      @(posedge mclk_in);
      b.power_on_rst_n_out <= 1'b1;
      #1;
      chk(int_por_out, 1'b1);
      @(posedge mclk_in);
      #1;
      chk(sdram_rst_n_out, 1'b0);
      wt(0, 1'b0, n);
      chk(n >= 35 && n <= 44, 1'b1);
      $display("power-on pulse test done");
      close_out();
   end
   // Watchdog
   initial begin
      #200000;
      n_fail++;
      close_out();
   end
endmodule
bind rss_reset_stretch_sequencer rss_chk_assertions chk_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
   .power_on_rst_n_in(power_on_rst_n_in), .int_por_out(int_por_out), .sdram_rst_n_out(sdram_rst_n_out),
   .internal_system_reset_n_out(internal_system_reset_n_out), .rst_pin_n_out(rst_pin_n_out));
